// file: src/sjt_pkg.sv
//==================================================================
package sjt_pkg;

  localparam int IR_W   = 3;
  localparam int ID_W   = 32;
  localparam int BSR_W  = 109;
  localparam int RING_W = 108;
  localparam int Q_W    = 36;
  localparam int OE_CELL = 108;

  localparam logic [2:0] IR_EXTEST  = 3'h0;
  localparam logic [2:0] IR_IDCODE  = 3'h1;
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] IR_PRELOAD = 3'h4;
  localparam logic [2:0] IR_BYPASS  = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  localparam int ID_REV_LSB   = 29;
  localparam int ID_PART_LSB  = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_PRES_BIT  = 0;

  localparam logic OE_CELL_RST = 1'b0;

  localparam int          ACLK_MHZ     = 50;
  localparam int          DLL_MIN_MHZ  = 120;
  localparam int          DLL_CNT_W    = 11;
  localparam logic [10:0] DLL_LOCK_CYC = 11'h400;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ID   = 8'h08;
  localparam int CTRL_RELOCK_BIT = 0;
  localparam int STAT_LOCK_BIT   = 0;
  localparam int STAT_IR_LSB     = 1;
  localparam int STAT_HIZ_BIT    = 4;
  localparam int STAT_EXT_BIT    = 5;
  localparam int STAT_LDN_BIT    = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
    TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
  } sjt_tap_e;

  typedef struct packed {
    logic [IR_W-1:0] ir;
    logic            oe_cell;
    logic [Q_W-1:0]  q;
  } sjt_xfer_s;

endpackage

// file: src/sjt_sync.sv
`timescale 1ns/10ps
module sjt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = rst_n ? d : '0;
    q_nxt    = rst_n ? meta_r : '0;
  end

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q      <= q_nxt;
  end

endmodule

// file: src/sjt_tap_fsm.sv
`timescale 1ns/10ps
module sjt_tap_fsm (
  // Test clock and reset
  input  wire logic      tck,
  input  wire logic      rst_n,
  // Mode select
  input  wire logic      tms,
  output sjt_pkg::sjt_tap_e state
);

  sjt_pkg::sjt_tap_e state_nxt;

  always_comb begin
    state_nxt = state;
    unique case (state)
      sjt_pkg::TS_RESET:  state_nxt = tms ? sjt_pkg::TS_RESET  : sjt_pkg::TS_IDLE;
      sjt_pkg::TS_IDLE:   state_nxt = tms ? sjt_pkg::TS_SEL_DR : sjt_pkg::TS_IDLE;
      sjt_pkg::TS_SEL_DR: state_nxt = tms ? sjt_pkg::TS_SEL_IR : sjt_pkg::TS_CAP_DR;
      sjt_pkg::TS_CAP_DR: state_nxt = tms ? sjt_pkg::TS_EX1_DR : sjt_pkg::TS_SH_DR;
      sjt_pkg::TS_SH_DR:  state_nxt = tms ? sjt_pkg::TS_EX1_DR : sjt_pkg::TS_SH_DR;
      sjt_pkg::TS_EX1_DR: state_nxt = tms ? sjt_pkg::TS_UPD_DR : sjt_pkg::TS_PA_DR;
      sjt_pkg::TS_PA_DR:  state_nxt = tms ? sjt_pkg::TS_EX2_DR : sjt_pkg::TS_PA_DR;
      sjt_pkg::TS_EX2_DR: state_nxt = tms ? sjt_pkg::TS_UPD_DR : sjt_pkg::TS_SH_DR;
      sjt_pkg::TS_UPD_DR: state_nxt = tms ? sjt_pkg::TS_SEL_DR : sjt_pkg::TS_IDLE;
      sjt_pkg::TS_SEL_IR: state_nxt = tms ? sjt_pkg::TS_RESET  : sjt_pkg::TS_CAP_IR;
      sjt_pkg::TS_CAP_IR: state_nxt = tms ? sjt_pkg::TS_EX1_IR : sjt_pkg::TS_SH_IR;
      sjt_pkg::TS_SH_IR:  state_nxt = tms ? sjt_pkg::TS_EX1_IR : sjt_pkg::TS_SH_IR;
      sjt_pkg::TS_EX1_IR: state_nxt = tms ? sjt_pkg::TS_UPD_IR : sjt_pkg::TS_PA_IR;
      sjt_pkg::TS_PA_IR:  state_nxt = tms ? sjt_pkg::TS_EX2_IR : sjt_pkg::TS_PA_IR;
      sjt_pkg::TS_EX2_IR: state_nxt = tms ? sjt_pkg::TS_UPD_IR : sjt_pkg::TS_SH_IR;
      sjt_pkg::TS_UPD_IR: state_nxt = tms ? sjt_pkg::TS_SEL_DR : sjt_pkg::TS_IDLE;
    endcase
    if (!rst_n) begin
      state_nxt = sjt_pkg::TS_RESET;
    end
  end

  always_ff @(posedge tck) begin
    state <= state_nxt;
  end

endmodule

// file: src/sjt_top.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sjt_top #(
  // Identity fields, values arbitrary
  parameter logic [2:0]  ID_REV   = 3'h0,
  parameter logic [16:0] ID_PART  = 17'h0a5a5,
  parameter logic [10:0] ID_MAKER = 11'h155
) (
  // System clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Test port
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo_o,
  output logic                             tdo_oe,
  // Pin ring and output bus
  input  wire logic [sjt_pkg::RING_W-1:0]  ring_in,
  input  wire logic [sjt_pkg::Q_W-1:0]     core_q,
  input  wire logic                        core_q_oe,
  output logic      [sjt_pkg::Q_W-1:0]     q_out,
  output logic                             q_oe,
  // Delay-locked loop
  input  wire logic                        loop_disable_n,
  output logic                             dll_locked
);

  localparam logic [31:0] ID_CODE = {ID_REV, ID_PART, ID_MAKER, 1'b1};

  //==================================================================
  // Test clock domain
  logic                        tck_rst_n;
  logic [sjt_pkg::RING_W-1:0]  ring_s;
  sjt_pkg::sjt_tap_e           tap;

  // Reset crosses into the test domain; flops land in reset state
  sjt_sync #(.W(1)) u_rst_sync (
    .clk   (tck),
    .rst_n (1'b1),
    .d     (aresetn),
    .q     (tck_rst_n)
  );

  // Pin ring levels are asynchronous to the test clock
  sjt_sync #(.W(sjt_pkg::RING_W)) u_ring_sync (
    .clk   (tck),
    .rst_n (tck_rst_n),
    .d     (ring_in),
    .q     (ring_s)
  );

  sjt_tap_fsm u_fsm (
    .tck   (tck),
    .rst_n (tck_rst_n),
    .tms   (tms),
    .state (tap)
  );

  logic [sjt_pkg::IR_W-1:0]   ir_r, ir_nxt;
  logic [sjt_pkg::IR_W-1:0]   irs_r, irs_nxt;
  logic [sjt_pkg::BSR_W-1:0]  bsr_r, bsr_nxt;
  logic [sjt_pkg::BSR_W-1:0]  upd_r, upd_nxt;
  logic [sjt_pkg::ID_W-1:0]   ids_r, ids_nxt;
  logic                       byp_r, byp_nxt;
  logic                       tgl_r, tgl_nxt;
  logic                       bsr_sel;

  // Reserved codes fall back to bypass
  always_comb begin
    bsr_sel = (ir_r == sjt_pkg::IR_EXTEST) || (ir_r == sjt_pkg::IR_SAMPLEZ)
           || (ir_r == sjt_pkg::IR_PRELOAD);
  end

  always_comb begin
    ir_nxt  = ir_r;
    irs_nxt = irs_r;
    bsr_nxt = bsr_r;
    upd_nxt = upd_r;
    ids_nxt = ids_r;
    byp_nxt = byp_r;
    tgl_nxt = tgl_r;
    unique case (tap)
      sjt_pkg::TS_RESET: begin
        ir_nxt           = sjt_pkg::IR_IDCODE;
        upd_nxt[sjt_pkg::OE_CELL] = sjt_pkg::OE_CELL_RST;
        tgl_nxt          = ~tgl_r;
      end
      sjt_pkg::TS_CAP_IR: irs_nxt = sjt_pkg::IR_CAPTURE;
      sjt_pkg::TS_SH_IR:  irs_nxt = {tdi, irs_r[sjt_pkg::IR_W-1:1]};
      sjt_pkg::TS_UPD_IR: begin
        ir_nxt  = irs_r;
        tgl_nxt = ~tgl_r;
      end
      sjt_pkg::TS_CAP_DR: begin
        if (bsr_sel) begin
          bsr_nxt = {upd_r[sjt_pkg::OE_CELL], ring_s};
        end
        ids_nxt = ID_CODE;
        byp_nxt = 1'b0;
      end
      sjt_pkg::TS_SH_DR: begin
        if (bsr_sel) begin
          bsr_nxt = {tdi, bsr_r[sjt_pkg::BSR_W-1:1]};
        end else if (ir_r == sjt_pkg::IR_IDCODE) begin
          ids_nxt = {tdi, ids_r[sjt_pkg::ID_W-1:1]};
        end else begin
          byp_nxt = tdi;
        end
      end
      sjt_pkg::TS_UPD_DR: begin
        if (bsr_sel) begin
          upd_nxt = bsr_r;
          tgl_nxt = ~tgl_r;
        end
      end
      default: ;
    endcase
    if (!tck_rst_n) begin
      ir_nxt  = sjt_pkg::IR_IDCODE;
      irs_nxt = '0;
      bsr_nxt = '0;
      upd_nxt = '0;
      ids_nxt = '0;
      byp_nxt = 1'b0;
      tgl_nxt = 1'b0;
      upd_nxt[sjt_pkg::OE_CELL] = sjt_pkg::OE_CELL_RST;
    end
  end

  always_ff @(posedge tck) begin
    ir_r  <= ir_nxt;
    irs_r <= irs_nxt;
    bsr_r <= bsr_nxt;
    upd_r <= upd_nxt;
    ids_r <= ids_nxt;
    byp_r <= byp_nxt;
    tgl_r <= tgl_nxt;
  end

  //==================================================================
  // Serial output, moved on the falling edge
  logic tdo_nxt;
  logic tdo_oe_nxt;

  always_comb begin
    tdo_nxt    = tdo_o;
    tdo_oe_nxt = 1'b0;
    if (tap == sjt_pkg::TS_SH_IR) begin
      tdo_nxt    = irs_r[0];
      tdo_oe_nxt = 1'b1;
    end else if (tap == sjt_pkg::TS_SH_DR) begin
      tdo_oe_nxt = 1'b1;
      if (bsr_sel) begin
        tdo_nxt = bsr_r[0];
      end else if (ir_r == sjt_pkg::IR_IDCODE) begin
        tdo_nxt = ids_r[0];
      end else begin
        tdo_nxt = byp_r;
      end
    end
    if (!tck_rst_n) begin
      tdo_nxt    = 1'b0;
      tdo_oe_nxt = 1'b0;
    end
  end

  always_ff @(negedge tck) begin
    tdo_o  <= tdo_nxt;
    tdo_oe <= tdo_oe_nxt;
  end

  //==================================================================
  // Crossing to system clock
  // Snapshot words only move on a toggle; they sit still for a whole
  // test cycle afterwards, far longer than the three-flop latency.
  logic                  tgl_s;
  logic                  tgl_d_r, tgl_d_nxt;
  sjt_pkg::sjt_xfer_s    xf_r, xf_nxt;

  sjt_sync #(.W(1)) u_tgl_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     (tgl_r),
    .q     (tgl_s)
  );

  always_comb begin
    tgl_d_nxt = tgl_s;
    xf_nxt    = xf_r;
    if (tgl_s != tgl_d_r) begin
      xf_nxt.ir      = ir_r;
      xf_nxt.oe_cell = upd_r[sjt_pkg::OE_CELL];
      xf_nxt.q       = upd_r[sjt_pkg::Q_W-1:0];
    end
    if (!aresetn) begin
      tgl_d_nxt      = 1'b0;
      xf_nxt.ir      = sjt_pkg::IR_IDCODE;
      xf_nxt.oe_cell = sjt_pkg::OE_CELL_RST;
      xf_nxt.q       = '0;
    end
  end

  always_ff @(posedge aclk) begin
    tgl_d_r <= tgl_d_nxt;
    xf_r    <= xf_nxt;
  end

  //==================================================================
  // Output bus
  logic [sjt_pkg::Q_W-1:0] q_out_nxt;
  logic                    q_oe_nxt;
  logic                    ext_on;
  logic                    hiz_on;

  always_comb begin
    ext_on    = (xf_r.ir == sjt_pkg::IR_EXTEST);
    hiz_on    = (xf_r.ir == sjt_pkg::IR_SAMPLEZ);
    q_out_nxt = core_q;
    q_oe_nxt  = core_q_oe;
    if (ext_on) begin
      q_out_nxt = xf_r.q;
      q_oe_nxt  = xf_r.oe_cell;
    end else if (hiz_on) begin
      q_oe_nxt = 1'b0;
    end
    if (!aresetn) begin
      q_out_nxt = '0;
      q_oe_nxt  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    q_out <= q_out_nxt;
    q_oe  <= q_oe_nxt;
  end

  //==================================================================
  // Delay-locked loop lock tracking
  // Counts system clocks standing in for the primary input clock;
  // real phase tracking is analogue and outside this logic.
  logic                          ldn_s;
  logic [sjt_pkg::DLL_CNT_W-1:0] dll_cnt_r, dll_cnt_nxt;
  logic                          dll_lock_nxt;
  logic                          relock;

  sjt_sync #(.W(1)) u_ldn_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     (loop_disable_n),
    .q     (ldn_s)
  );

  always_comb begin
    dll_cnt_nxt  = dll_cnt_r;
    dll_lock_nxt = dll_locked;
    if (!ldn_s || relock) begin
      dll_cnt_nxt  = '0;
      dll_lock_nxt = 1'b0;
    end else if (dll_cnt_r != sjt_pkg::DLL_LOCK_CYC) begin
      dll_cnt_nxt = dll_cnt_r + 11'h001;
    end else begin
      dll_lock_nxt = 1'b1;
    end
    if (!aresetn) begin
      dll_cnt_nxt  = '0;
      dll_lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    dll_cnt_r  <= dll_cnt_nxt;
    dll_locked <= dll_lock_nxt;
  end

  //==================================================================
  // AXI4-Lite slave
  logic        aw_hold_r, aw_hold_nxt;
  logic        w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt, stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[sjt_pkg::STAT_LOCK_BIT] = dll_locked;
    stat_word[sjt_pkg::STAT_IR_LSB +: sjt_pkg::IR_W] = xf_r.ir;
    stat_word[sjt_pkg::STAT_HIZ_BIT] = hiz_on;
    stat_word[sjt_pkg::STAT_EXT_BIT] = ext_on;
    stat_word[sjt_pkg::STAT_LDN_BIT] = ldn_s;
  end

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    relock      = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = sjt_pkg::RESP_OKAY;
      if (awaddr_r == sjt_pkg::REG_CTRL) begin
        relock = wstrb0_r && wdata_r[sjt_pkg::CTRL_RELOCK_BIT];
      end else if (awaddr_r != sjt_pkg::REG_STAT && awaddr_r != sjt_pkg::REG_ID) begin
        bresp_nxt = sjt_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_hold_nxt && !(s_axi_awvalid && s_axi_awready);
    wready_nxt  = !w_hold_nxt && !(s_axi_wvalid && s_axi_wready);
    if (!aresetn) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      awaddr_nxt  = '0;
      wdata_nxt   = '0;
      wstrb0_nxt  = 1'b0;
      bvalid_nxt  = 1'b0;
      bresp_nxt   = sjt_pkg::RESP_OKAY;
      awready_nxt = 1'b0;
      wready_nxt  = 1'b0;
      relock      = 1'b0;
    end
  end

  always_comb begin
    arready_nxt = s_axi_arready;
    rvalid_nxt  = s_axi_rvalid;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = sjt_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sjt_pkg::REG_CTRL: rdata_nxt = '0;
        sjt_pkg::REG_STAT: rdata_nxt = stat_word;
        sjt_pkg::REG_ID:   rdata_nxt = ID_CODE;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = sjt_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end else if (!s_axi_rvalid) begin
      arready_nxt = 1'b1;
    end
    if (!aresetn) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b0;
      rdata_nxt   = '0;
      rresp_nxt   = sjt_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    aw_hold_r     <= aw_hold_nxt;
    w_hold_r      <= w_hold_nxt;
    awaddr_r      <= awaddr_nxt;
    wdata_r       <= wdata_nxt;
    wstrb0_r      <= wstrb0_nxt;
    s_axi_awready <= awready_nxt;
    s_axi_wready  <= wready_nxt;
    s_axi_bvalid  <= bvalid_nxt;
    s_axi_bresp   <= bresp_nxt;
    s_axi_arready <= arready_nxt;
    s_axi_rvalid  <= rvalid_nxt;
    s_axi_rdata   <= rdata_nxt;
    s_axi_rresp   <= rresp_nxt;
  end

endmodule

// file: sim/sjt_props.sv
`timescale 1ns/10ps
module sjt_props (
  // System side
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Test port and loop
  input wire logic        tck,
  input wire logic        tdo_o,
  input wire logic        tdo_oe,
  input wire logic        loop_disable_n,
  input wire logic        dll_locked
);
  logic [11:0] hi_cnt_r;
  logic [11:0] hi_cnt_nxt;
  logic        relock;
  // ==========
  // Stable-pin cycle count, cleared by a relock write
  always_comb begin
    relock = s_axi_wvalid && s_axi_wready && s_axi_wdata[0] &&
             (s_axi_awaddr == sjt_pkg::REG_CTRL);
    hi_cnt_nxt = hi_cnt_r;
    if (!aresetn || !loop_disable_n || relock) begin
      hi_cnt_nxt = 12'h000;
    end else if (hi_cnt_r != 12'hfff) begin
      hi_cnt_nxt = hi_cnt_r + 12'h001;
    end
  end
  always_ff @(posedge aclk) begin
    hi_cnt_r <= hi_cnt_nxt;
  end
  // ==========
  // Checks, all sampled on aclk (tck is far slower)
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tdo_stable: assert property (tck && $past(tck) |-> $stable(tdo_o) && $stable(tdo_oe))
    else $error("serial output moved while test clock high");
  a_lock_early: assert property ($rose(dll_locked) |-> hi_cnt_r >= 12'h400)
    else $error("loop locked too early");
  a_lock_late: assert property (hi_cnt_r == 12'h410 |-> dll_locked)
    else $error("loop failed to lock");
  a_lock_drop: assert property ($fell(loop_disable_n) |-> ##[1:4] !dll_locked)
    else $error("lock kept after loop disabled");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  c_lock: cover property ($rose(dll_locked));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_shift: cover property ($rose(tdo_oe));
endmodule

// file: sim/sjt_jtag_host.sv
`timescale 1ns/10ps
module sjt_jtag_host (
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_o,
  input  wire logic tdo_oe,
  // Loop pin
  output logic      loop_disable_n
);
  // Pin driven high from power-up; only loop_en changes it
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    loop_disable_n = 1'b1;
  end
  // One test clock cycle; tdo taken at the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    o = tdo_o;
    #80 tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic o;
    #7;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask
  // Shift LSB first; takes effect at update. Codes only as the bench asks
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout);
    logic o;
    dout = '0;
    #7;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask
  // Dropping the pin forces a fresh lock
  task automatic loop_en(input logic v);
    loop_disable_n <= v;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [2:0]   ID_R = 3'h5;      // Arbitrary
  localparam logic [16:0]  ID_P = 17'h0c3a9; // Arbitrary
  localparam logic [10:0]  ID_M = 11'h2b6;   // Arbitrary
  localparam logic [31:0]  ID_X = {ID_R, ID_P, ID_M, 1'b1};
  localparam logic [107:0] RING = {4{27'h5a3c0f1}};
  localparam logic [35:0]  PAT  = 36'h9a5c30f1e;
  logic        aclk, aresetn, tck, tms, tdi, tdo_o, tdo_oe, loop_disable_n, dll_locked;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        core_q_oe, q_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [107:0] ring_in;
  logic [35:0] core_q, q_out;
  int          n_errors, check_count, cyc;
  sjt_top #(.ID_REV(ID_R), .ID_PART(ID_P), .ID_MAKER(ID_M)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tck, .tms,
    .tdi, .tdo_o, .tdo_oe, .ring_in, .core_q, .core_q_oe, .q_out, .q_oe, .loop_disable_n,
    .dll_locked);
  sjt_jtag_host host_u (.tck, .tms, .tdi, .tdo_o, .tdo_oe, .loop_disable_n);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [108:0] got, input logic [108:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Handshake flags read at the falling edge, where registered outputs are settled
  // Ready held from the request on; only the bench timeout ends a wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready; w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready; r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rg;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready; rg = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata; r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rg) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic ir(input logic [2:0] c);
    logic [108:0] o;
    host_u.scan(1'b1, 3, {106'h0, c}, o);
    chk("ir_capture", o[2:0], 3'h1);
  endtask
  task automatic dr(input int n, input logic [108:0] d, output logic [108:0] o);
    host_u.scan(1'b0, n, d, o);
    repeat (10) @(negedge aclk);
    chk("oe_idle", tdo_oe, 1'b0);
  endtask
  // ==========
  // Scenarios
  task automatic t_idcode();
    logic [108:0] o; logic [31:0] r; logic [1:0] rs;
    dr(32, '0, o);
    chk("idcode", o[31:0], ID_X);
    chk("id_present", o[0], 1'b1);
    axi_rd(sjt_pkg::REG_ID, r, rs);
    chk("id_fields", {rs, r}, {sjt_pkg::RESP_OKAY, ID_X});
    chk("id_pass", {q_oe, q_out}, {core_q_oe, core_q});
  endtask
  task automatic t_boundary();
    logic [108:0] o; logic [31:0] r; logic [1:0] rs;
    ir(3'h4);
    dr(109, {1'b1, 72'h0, PAT}, o);
    chk("pre_cap", o, {1'b0, RING});
    chk("pre_pass", {q_oe, q_out}, {core_q_oe, core_q});
    ir(3'h0);
    dr(109, {1'b0, 72'h0, PAT}, o);
    chk("ext_cap", o, {1'b1, RING});
    chk("ext_hiz", {q_oe, q_out}, {1'b0, PAT});
    dr(109, {1'b1, 72'h0, PAT}, o);
    chk("ext_drive", {q_oe, q_out}, {1'b1, PAT});
    ir(3'h2);
    dr(109, '0, o);
    chk("sz_cap", o, {1'b1, RING});
    chk("sz_oe", q_oe, 1'b0);
    axi_rd(sjt_pkg::REG_STAT, r, rs);
    chk("sz_stat", r[4:1], 4'ha);
  endtask
  task automatic t_bypass();
    logic [108:0] o;
    logic [3:0] v[2] = '{4'hb, 4'h4};
    // Reserved codes are never loaded; bypass is its own code
    ir(3'h7);
    foreach (v[i]) begin
      dr(4, {105'h0, v[i]}, o);
      chk("bypass", o[3:0], {v[i][2:0], 1'b0});
      chk("byp_pass", {q_oe, q_out}, {core_q_oe, core_q});
    end
  endtask
  task automatic t_tlr();
    logic [108:0] o; logic [31:0] r; logic [1:0] rs;
    ir(3'h0);
    host_u.reset_tap();
    repeat (10) @(negedge aclk);
    axi_rd(sjt_pkg::REG_STAT, r, rs);
    chk("tlr_ir", r[3:1], 3'h1);
    dr(32, '0, o);
    chk("tlr_id", o[31:0], ID_X);
  endtask
  task automatic t_axi();
    logic [31:0] r; logic [1:0] rs;
    axi_rd(8'h10, r, rs);
    chk("rd_bad", {rs, r}, {sjt_pkg::RESP_SLVERR, 32'h0});
    axi_wr(8'h10, 32'h0, rs);
    chk("wr_bad", rs, sjt_pkg::RESP_SLVERR);
    axi_wr(sjt_pkg::REG_ID, 32'h0, rs);
    axi_rd(sjt_pkg::REG_ID, r, rs);
    chk("id_ro", r, ID_X);
    axi_rd(sjt_pkg::REG_CTRL, r, rs);
    chk("ctrl_rd", r, 32'h0);
  endtask
  task automatic t_dll();
    logic [1:0] rs;
    chk("locked", dll_locked, 1'b1);
    host_u.loop_en(1'b0);
    repeat (6) @(negedge aclk);
    chk("unlock", dll_locked, 1'b0);
    host_u.loop_en(1'b1);
    repeat (1000) @(negedge aclk);
    chk("early", dll_locked, 1'b0);
    for (int k = 0; k < 60 && dll_locked !== 1'b1; k++) @(negedge aclk);
    chk("relocked", dll_locked, 1'b1);
    axi_wr(sjt_pkg::REG_CTRL, 32'h1, rs);
    repeat (4) @(negedge aclk);
    chk("ctrl_unlock", {rs, dll_locked}, {sjt_pkg::RESP_OKAY, 1'b0});
  endtask
  initial begin
    aresetn = 1'b0; s_axi_awaddr = 8'h0; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; ring_in = RING;
    core_q = 36'h31c2d7e48; core_q_oe = 1'b1;
    // Test clock must see the reset too
    fork
      host_u.reset_tap();
      repeat (10) @(posedge aclk);
    join
    @(posedge aclk) aresetn <= 1'b1;
    host_u.reset_tap();
    t_idcode(); t_boundary(); t_bypass(); t_tlr(); t_axi(); t_dll();
    final_report();
  end
endmodule
bind sjt_top sjt_props chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .tck, .tdo_o, .tdo_oe, .loop_disable_n, .dll_locked);
